// ### verilog/sacc_regs.svh
`ifndef SACC_REGS_SVH
`define SACC_REGS_SVH

// Result width and byte-lane width of the multiplexed format
`define SACC_RES_W        12
`define SACC_BYTE_W       8
// Timing in ns, converted to cycles in the main file
`define SACC_CLK_NS       10
`define SACC_APERTURE_NS  20
`define SACC_CONV_NS      5000
// Result FIFO depth
`define SACC_FIFO_DEPTH   8
// Reset value of the held result
`define SACC_RES_RST      12'h000

`endif

// ### verilog/sacc_pkg.sv
package sacc_pkg;

  // Conversion sequencer states, Gray coded along the path
  typedef enum logic [1:0] {
    SACC_IDLE    = 2'b00,
    SACC_APERT   = 2'b01,
    SACC_CONVERT = 2'b11,
    SACC_STORE   = 2'b10
  } sacc_state_type;

  // Host control pins after synchronisation
  typedef struct packed {
    logic chip_select_n;
    logic conversion_trigger_n;
    logic output_enable_n;
    logic done_flag_enable_n;
    logic upper_byte_select_n;
  } sacc_ctrl_type;

  // Pin straps
  typedef struct packed {
    logic sync_mode;
    logic wide_format;
    logic right_justify;
    logic bipolar;
  } sacc_strap_type;

endpackage

// ### verilog/sacc_fifo.sv
`timescale 1ns/1ps
// Small flip-flop FIFO with valid/ready on both sides
module sacc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,   // System clock
  input  wire logic             rst,       // Synchronous reset
  input  wire logic [WIDTH-1:0] in_data,   // Write data
  input  wire logic             in_valid,  // Write request
  output logic                  in_ready,  // Not full
  output logic [WIDTH-1:0]      out_data,  // Head word
  output logic                  out_valid, // Not empty
  input  wire logic             out_ready  // Pop request
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];  // Storage
  logic [AW-1:0]    wr_q;           // Write index
  logic [AW-1:0]    rd_q;           // Read index
  logic [AW:0]      cnt_q;          // Fill level
  logic             push;           // Accepted write
  logic             pop;            // Accepted read

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Index wrap helper
  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    nxt = (p == (AW)'(DEPTH-1)) ? '0 : p + 1'b1;
  endfunction

  // Storage write
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and level
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= nxt(wr_q);
      end
      if (pop) begin
        rd_q <= nxt(rd_q);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_no_overflow : assert property (@(posedge sys_clk) disable iff (rst)
    cnt_q <= (AW+1)'(DEPTH)) else $error("FIFO level above depth");
endmodule

// ### verilog/sacc_ctrl.sv
`timescale 1ns/1ps
`include "sacc_regs.svh"
// Notes on behaviour
// - Trigger is active low, gated per mode
// - Sync mode: chip select gates trigger, flag
// - Async mode: ungated trigger, open-drain flag
// - Wide strap: full result in one read
// - Narrow strap: result in two byte reads
// - Data and flag outputs three-state when not enabled
// - Sample taken aperture delay after trigger fall
// - Bipolar: twos complement result coding
// - Flag low while converting, high when done
// - Data driven only with select and enable
// - Byte select low high byte, high low
module sacc_ctrl #(
  parameter int CONV_NS = `SACC_CONV_NS     // Conversion time
) (
  input  wire logic                  sys_clk,              // System clock
  input  wire logic                  rst,                  // Synchronous reset
  input  wire logic                  chip_select_n,        // Chip select pin
  input  wire logic                  conversion_trigger_n, // Trigger pin
  input  wire logic                  output_enable_n,      // Read enable pin
  input  wire logic                  done_flag_enable_n,   // Flag enable pin
  input  wire logic                  sync_strap,           // High: synchronous
  input  wire logic                  wide_strap,           // High: 12-bit format
  input  wire logic                  right_justify,        // Byte justification
  input  wire logic                  bipolar_offset_input, // High: bipolar
  input  wire logic [11:0]           sample_in,            // Digitised sample
  input  wire logic                  upper_byte_select_n,  // Byte select in
  output logic      [11:0]           result_data_pins,     // Data out
  output logic      [11:0]           result_data_oe,       // Data enables
  output logic                       done_flag,            // Flag out
  output logic                       done_flag_oe,         // Flag enable
  output logic                       result_lost           // FIFO full on store
);
  localparam int AP_CYC = (`SACC_APERTURE_NS + `SACC_CLK_NS - 1) / `SACC_CLK_NS;
  localparam int CV_CYC = (CONV_NS + `SACC_CLK_NS - 1) / `SACC_CLK_NS;

  sacc_pkg::sacc_ctrl_type  m1_q;      // First sync stage
  sacc_pkg::sacc_ctrl_type  c_q;       // Synchronised pins
  sacc_pkg::sacc_strap_type s1_q;      // First strap stage
  sacc_pkg::sacc_strap_type s_q;       // Synchronised straps
  logic                     trig_d1_q; // Previous gated trigger
  sacc_pkg::sacc_state_type st_q;      // Sequencer state
  logic [15:0]              tmr_q;     // Phase timer
  logic [11:0]              samp_q;    // Held sample
  logic [11:0]              res_q;     // Output register
  logic                     busy_q;    // Conversion in progress
  logic [11:0]              fifo_out;  // FIFO head
  logic                     fifo_vld;  // FIFO not empty
  logic                     fifo_rdy;  // FIFO not full
  logic                     push;      // Store result
  logic                     pop;       // Load output register
  logic                     trig_g;    // Gated trigger level
  logic                     rd_en;     // Read window
  logic                     fl_en;     // Flag window
  logic [11:0]              out_d;     // Formatted data
  logic                     res_vld_q; // Output register holds an unread result
  logic                     rd_d1_q;   // Previous read window
  logic                     rd_ub_q;   // Byte select seen in the last read cycle
  logic                     consumed;  // Held result fully read out

  // Two-stage synchronisers for all pins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      m1_q <= '1;
      c_q  <= '1;
      s1_q <= '0;
      s_q  <= '0;
    end else begin
      m1_q <= {chip_select_n, conversion_trigger_n, output_enable_n,
               done_flag_enable_n, upper_byte_select_n};
      c_q  <= m1_q;
      s1_q <= {sync_strap, wide_strap, right_justify, bipolar_offset_input};
      s_q  <= s1_q;
    end
  end

  // Trigger gating: chip select (active low) qualifies in sync mode
  assign trig_g = !c_q.conversion_trigger_n &&
                  (!s_q.sync_mode || !c_q.chip_select_n);
  assign rd_en  = !c_q.chip_select_n && !c_q.output_enable_n;
  assign fl_en  = !c_q.done_flag_enable_n &&
                  (!s_q.sync_mode || !c_q.chip_select_n);

  // Falling-edge memory of the gated trigger
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      trig_d1_q <= 1'b0;
    end else begin
      trig_d1_q <= trig_g;
    end
  end

  // Conversion sequencer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q   <= sacc_pkg::SACC_IDLE;
      tmr_q  <= '0;
      busy_q <= 1'b0;
      samp_q <= `SACC_RES_RST;
    end else begin
      case (st_q)
        sacc_pkg::SACC_IDLE: begin
          // Start on gated trigger falling edge
          if (trig_g && !trig_d1_q) begin
            st_q   <= sacc_pkg::SACC_APERT;
            tmr_q  <= 16'(AP_CYC - 1);
            busy_q <= 1'b1;
          end
        end
        sacc_pkg::SACC_APERT: begin
          // Capture the input after the aperture delay
          if (tmr_q == '0) begin
            samp_q <= sample_in;
            st_q   <= sacc_pkg::SACC_CONVERT;
            tmr_q  <= 16'(CV_CYC - 1);
          end else begin
            tmr_q <= tmr_q - 16'h0001;
          end
        end
        sacc_pkg::SACC_CONVERT: begin
          // Conversion body
          if (tmr_q == '0) begin
            st_q <= sacc_pkg::SACC_STORE;
          end else begin
            tmr_q <= tmr_q - 16'h0001;
          end
        end
        sacc_pkg::SACC_STORE: begin
          // Result stored, flag returns high
          st_q   <= sacc_pkg::SACC_IDLE;
          busy_q <= 1'b0;
        end
        default: begin
          st_q <= sacc_pkg::SACC_IDLE;
        end
      endcase
    end
  end

  assign push = (st_q == sacc_pkg::SACC_STORE);

  // Lost result indicator
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      result_lost <= 1'b0;
    end else begin
      result_lost <= push && !fifo_rdy;
    end
  end

  sacc_fifo #(
    .WIDTH(`SACC_RES_W),
    .DEPTH(`SACC_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .in_data  (samp_q),
    .in_valid (push),
    .in_ready (fifo_rdy),
    .out_data (fifo_out),
    .out_valid(fifo_vld),
    .out_ready(pop)
  );

  // Read tracking: byte select is remembered because it is released with the read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_d1_q <= 1'b0;
      rd_ub_q <= 1'b1;
    end else begin
      rd_d1_q <= rd_en;
      if (rd_en) begin
        rd_ub_q <= c_q.upper_byte_select_n;
      end
    end
  end

  // A result is used up after a wide read or after its low-byte read
  assign consumed = rd_d1_q && !rd_en && (s_q.wide_format || rd_ub_q);

  // Load the next result only outside a read and once the held one is read
  assign pop = fifo_vld && !rd_en && !res_vld_q;

  // Unread-result flag; a load in the same cycle as a consume wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      res_vld_q <= 1'b0;
    end else if (pop) begin
      res_vld_q <= 1'b1;
    end else if (consumed) begin
      res_vld_q <= 1'b0;
    end
  end

  // Output register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      res_q <= `SACC_RES_RST;
    end else if (pop) begin
      res_q <= fifo_out;
    end
  end

  // Output formatting per width and byte select
  always_comb begin
    out_d = '0;
    if (s_q.wide_format) begin
      out_d = res_q;
    end else if (s_q.right_justify) begin
      if (!c_q.upper_byte_select_n) begin
        out_d[11:4] = s_q.bipolar ? {{4{res_q[11]}}, res_q[11:8]}
                                  : {4'h0, res_q[11:8]};
      end else begin
        out_d[11:4] = res_q[7:0];
      end
    end else begin
      if (!c_q.upper_byte_select_n) begin
        out_d[11:4] = res_q[11:4];
      end else begin
        out_d[11:4] = {res_q[3:0], 4'h0};
      end
    end
  end

  // Registered pin drivers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      result_data_pins <= '0;
      result_data_oe   <= '0;
      done_flag        <= 1'b0;
      done_flag_oe     <= 1'b0;
    end else begin
      result_data_pins <= out_d;
      result_data_oe   <= !rd_en ? 12'h000 :
                          (s_q.wide_format ? 12'hfff : 12'hff0);
      done_flag        <= !busy_q;
      // Open drain in async mode: drive only the low level
      done_flag_oe     <= fl_en && (s_q.sync_mode || busy_q);
    end
  end

  a_flag_low_busy : assert property (@(posedge sys_clk) disable iff (rst)
    $rose(busy_q) |=> !done_flag) else $error("flag not low");
  a_data_float : assert property (@(posedge sys_clk) disable iff (rst)
    !rd_en |=> result_data_oe == 12'h000) else $error("data driven");
  a_flag_float : assert property (@(posedge sys_clk) disable iff (rst)
    !fl_en |=> !done_flag_oe) else $error("flag driven");
  a_async_od : assert property (@(posedge sys_clk) disable iff (rst)
    done_flag_oe && !s_q.sync_mode && $stable(s_q) |-> !done_flag)
    else $error("open drain high");
  a_sync_gate : assert property (@(posedge sys_clk) disable iff (rst)
    s_q.sync_mode && c_q.chip_select_n && st_q == sacc_pkg::SACC_IDLE |=>
    st_q == sacc_pkg::SACC_IDLE) else $error("conversion started without select");
  a_aperture : assert property (@(posedge sys_clk) disable iff (rst)
    st_q == sacc_pkg::SACC_IDLE && trig_g && !trig_d1_q |=> ##1
    st_q == sacc_pkg::SACC_APERT) else $error("aperture");
  a_wide_enable : assert property (@(posedge sys_clk) disable iff (rst)
    rd_en && s_q.wide_format && $stable(s_q) |=> result_data_oe == 12'hfff)
    else $error("wide");
  a_narrow_enable : assert property (@(posedge sys_clk) disable iff (rst)
    rd_en && !s_q.wide_format && $stable(s_q) |=> result_data_oe == 12'hff0)
    else $error("narrow");
  c_conv : cover property (@(posedge sys_clk) push);
  c_read : cover property (@(posedge sys_clk) rd_en && !s_q.wide_format);
  c_full : cover property (@(posedge sys_clk) !fifo_rdy);
endmodule

// ### verif/sacc_host_model.sv
`timescale 1ns/1ps
// Host bus master: owns the control pins and resolves the shared wires
module sacc_host_model (
  input  wire logic        sys_clk,              // Clock
  input  wire logic        sync_mode,            // Gating strap
  input  wire logic [11:0] pins,                 // Device data
  input  wire logic [11:0] pins_oe,              // Data enables
  input  wire logic        flag,                 // Device flag
  input  wire logic        flag_oe,              // Flag enable
  output logic             chip_select_n,        // Select
  output logic             conversion_trigger_n, // Trigger
  output logic             output_enable_n,      // Read enable
  output logic             done_flag_enable_n,   // Flag enable
  output logic             upper_byte_select_n,  // Byte select
  output logic [11:0]      data_bus,             // Data wires
  output logic             flag_wire             // Flag wire
);
  logic [11:0] bus_last = 12'h000; // Last data wire levels
  logic        flag_last = 1'b0;   // Last flag wire level
  // Remember wire levels so released wires can show their inverse
  always @(posedge sys_clk) begin
    bus_last  <= data_bus;
    flag_last <= flag_wire;
  end
  // Undriven wires toggle; the flag has a pull-up only when asynchronous
  always_comb begin
    data_bus = (pins & pins_oe) | (~bus_last & ~pins_oe);
    if (flag_oe) begin
      flag_wire = flag;
    end else begin
      flag_wire = sync_mode ? ~flag_last : 1'b1;
    end
  end
  // Pins idle deasserted
  initial begin
    {chip_select_n, conversion_trigger_n, output_enable_n} = 3'b111;
    {done_flag_enable_n, upper_byte_select_n} = 2'b11;
  end
  // Drive select, flag enable, read enable and byte select (active low)
  task automatic set(input logic cs, input logic en, input logic oe, input logic ub);
    @(posedge sys_clk);
    chip_select_n       <= cs;
    done_flag_enable_n  <= en;
    output_enable_n     <= oe;
    upper_byte_select_n <= ub;
  endtask
  // Trigger pulse; callers select beforehand when synchronous
  task automatic start();
    @(posedge sys_clk);
    conversion_trigger_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    conversion_trigger_n <= 1'b1;
  endtask
endmodule

// ### verif/tb_sacc_ctrl.sv
`timescale 1ns/1ps
// Bench: every strap setting, gating, reads, FIFO fill and drain
module tb_sacc_ctrl;
  localparam int LIMIT = 5000;              // Cycle ceiling
  logic        sys_clk, rst, hit;           // Clock, reset, wait result
  logic [3:0]  st;                          // Straps: sync wide rj bipolar
  logic [11:0] sample_in, pins, pins_oe;    // Sample and data side
  logic [11:0] data_bus, v, o, fs [9];      // Wires, reads, fill samples
  logic        flag, flag_oe, lost, flag_wire; // Flag side
  logic        cs_n, trig_n, oe_n, en_n, ub_n; // Host pins
  int          mismatches = 0, n_checks = 0, cycles = 0, lost_n = 0; // Counters
  // Clock, 10 ns period
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  sacc_ctrl #(.CONV_NS(200)) u_sacc_ctrl (.sys_clk(sys_clk), .rst(rst),
    .chip_select_n(cs_n), .conversion_trigger_n(trig_n), .output_enable_n(oe_n),
    .done_flag_enable_n(en_n), .sync_strap(st[3]), .wide_strap(st[2]),
    .right_justify(st[1]), .bipolar_offset_input(st[0]), .sample_in(sample_in),
    .upper_byte_select_n(ub_n), .result_data_pins(pins), .result_data_oe(pins_oe),
    .done_flag(flag), .done_flag_oe(flag_oe), .result_lost(lost));
  sacc_host_model u_sacc_host_model (.sys_clk(sys_clk), .sync_mode(st[3]), .pins(pins),
    .pins_oe(pins_oe), .flag(flag), .flag_oe(flag_oe), .chip_select_n(cs_n),
    .conversion_trigger_n(trig_n), .output_enable_n(oe_n), .done_flag_enable_n(en_n),
    .upper_byte_select_n(ub_n), .data_bus(data_bus), .flag_wire(flag_wire));
  // Cycle ceiling and count of dropped results
  always @(posedge sys_clk) begin
    cycles++;
    if (lost === 1'b1) lost_n++;
    if (cycles == LIMIT) begin
      mismatches++;
      finish_test();
    end
  end
  // Expected byte of an 8-bit read
  function automatic logic [7:0] exp_byte(input logic [11:0] s, input logic hi, rj, bip);
    if (rj) return hi ? {(bip ? {4{s[11]}} : 4'h0), s[11:8]} : s[7:0];
    return hi ? s[11:4] : {s[3:0], 4'h0};
  endfunction
  // Compare and report
  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // Wait a bounded number of cycles for a flag wire level
  task automatic wait_flag(input logic lvl, input int lim);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(posedge sys_clk);
      #1 hit = (flag_wire === lvl);
    end
  endtask
  // One read cycle, then release and check the data float
  task automatic rd(input logic ub);
    u_sacc_host_model.set(1'b0, 1'b0, 1'b0, ub);
    repeat (5) @(posedge sys_clk);
    #1 v = data_bus;
    o = pins_oe;
    u_sacc_host_model.set(1'b1, 1'b1, 1'b1, 1'b1);
    repeat (5) @(posedge sys_clk);
    #1 check(pins_oe, 12'h000, "data float");
  endtask
  // Wait a few cycles and sample
  task automatic settle();
    repeat (5) @(posedge sys_clk);
    #1;
  endtask
  // One conversion in a strap setting, then read it back
  task automatic convert(input logic [3:0] m, input logic [11:0] s);
    st <= m;
    sample_in <= s;
    u_sacc_host_model.set(~m[3], 1'b0, 1'b1, 1'b1);
    repeat (4) @(posedge sys_clk);
    u_sacc_host_model.start();
    wait_flag(1'b0, 12);
    check({11'h0, hit & flag_oe}, 12'h1, "flag low driven");
    sample_in <= ~s;
    wait_flag(1'b1, 40);
    check({11'h0, hit}, 12'h1, "flag back high");
    if (!m[3]) check({11'h0, flag_oe}, 12'h0, "open drain released");
    repeat (4) @(posedge sys_clk);
    rd(1'b0);
    if (m[2]) begin
      check(v, s, "wide word");
      check(o, 12'hfff, "wide enables");
    end else begin
      check({4'h0, v[11:4]}, {4'h0, exp_byte(s, 1'b1, m[1], m[0])}, "high byte");
      check({4'h0, o[11:4]}, 12'h0ff, "byte enables");
      rd(1'b1);
      check({4'h0, v[11:4]}, {4'h0, exp_byte(s, 1'b0, m[1], m[0])}, "low byte");
    end
  endtask
  // Closing report
  task automatic finish_test();
    $display("mismatches %0d checks %0d", mismatches, n_checks);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    st = 4'hc;
    sample_in = 12'h000;
    void'($urandom(32'h2e60));
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    // Synchronous trigger with select high must start nothing
    u_sacc_host_model.set(1'b1, 1'b0, 1'b1, 1'b1);
    u_sacc_host_model.start();
    u_sacc_host_model.set(1'b0, 1'b1, 1'b1, 1'b1);
    settle();
    check({11'h0, flag_oe}, 12'h0, "flag without enable");
    u_sacc_host_model.set(1'b1, 1'b1, 1'b0, 1'b1);
    settle();
    check(pins_oe, 12'h000, "data without select");
    u_sacc_host_model.set(1'b0, 1'b0, 1'b1, 1'b1);
    settle();
    check({10'h0, flag_oe, flag}, 12'h3, "no conversion started");
    for (int m = 0; m < 16; m++) convert(m[3:0], 12'($urandom));
    for (int k = 0; k < 3; k++) convert(4'hb, k == 0 ? 12'h800 : (k == 1 ? 12'hfff : 12'h7ff));
    // Fill the FIFO while a read is held open, then drain it
    st <= 4'hc;
    u_sacc_host_model.set(1'b0, 1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 9; i++) begin
      fs[i] = 12'($urandom);
      sample_in <= fs[i];
      u_sacc_host_model.start();
      wait_flag(1'b0, 12);
      wait_flag(1'b1, 40);
      check({11'h0, hit}, 12'h1, "fill conversion");
    end
    u_sacc_host_model.set(1'b1, 1'b1, 1'b1, 1'b1);
    settle();
    check(lost_n[11:0], 12'h1, "one result dropped");
    for (int i = 0; i < 8; i++) begin
      rd(1'b0);
      check(v, fs[i], "drained word");
    end
    finish_test();
  end
endmodule
